/* File: common/xtd_pkg.sv */
// Purpose: Shared constants for the tail instruction decoder.
// Assumes: One core clock at 40 MHz.
// Notes: Opcodes, clock counts, fault vectors and flag positions.
package xtd_pkg;
  localparam logic [7:0] OP_ESC = 8'h0F;
  localparam logic [7:0] OP_STD = 8'hFD;
  localparam logic [7:0] OP_STI = 8'hFB;
  localparam logic [7:0] OP_WAIT = 8'h9B;
  localparam logic [7:0] OP2_SVSEG = 8'h78;
  localparam logic [7:0] OP2_SAVE_LOCAL_TABLE_OP = 8'h7A;
  localparam logic [7:0] OP2_SVTSK = 8'h7C;
  localparam logic [7:0] OP2_GRP6 = 8'h00;
  localparam logic [7:0] OP2_FLUSH = 8'h09;
  localparam logic [7:0] OP2_MSRW = 8'h30;
  localparam logic [6:0] OP2_EXCHANGE_ADD_OP = 7'h60;
  localparam logic [2:0] REG_VRD = 3'h4;
  localparam logic [2:0] REG_VWR = 3'h5;
  localparam logic [2:0] REG_SUB = 3'h5;
  localparam logic [2:0] REG_XOR = 3'h6;
  localparam logic [2:0] REG_ZERO = 3'h0;
  localparam logic [7:0] CYC_STD = 8'h04;
  localparam logic [7:0] CYC_STI = 8'h06;
  localparam logic [7:0] CYC_ALU = 8'h01;
  localparam logic [7:0] CYC_SVSEG = 8'h14;
  localparam logic [7:0] CYC_SVTSK = 8'h15;
  localparam logic [7:0] CYC_VER = 8'h08;
  localparam logic [7:0] CYC_WAIT = 8'h01;
  localparam logic [7:0] CYC_FLUSH = 8'h17;
  localparam logic [7:0] CYC_MSRW = 8'h01;
  localparam logic [7:0] CYC_XCH = 8'h02;
  localparam logic [4:0] VEC_UD = 5'h06;
  localparam logic [4:0] VEC_SS = 5'h0C;
  localparam logic [4:0] VEC_GP = 5'h0D;
  localparam logic [31:0] REAL_LIMIT = 32'h0000FFFF;
  localparam int FL_CF = 0;
  localparam int FL_PF = 2;
  localparam int FL_AF = 4;
  localparam int FL_ZF = 6;
  localparam int FL_SF = 7;
  localparam int FL_IF = 9;
  localparam int FL_DF = 10;
  localparam int FL_OF = 11;
  localparam logic [11:0] FLAGS_RESET = 12'h002;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_EXEC = 6'h02,
    ST_WAITF = 6'h04,
    ST_FLUSH = 6'h08,
    ST_LOCKD = 6'h10,
    ST_DONE = 6'h20
  } xtd_state_t;
  typedef enum logic [3:0] {
    K_NONE = 4'h0, K_STD = 4'h1, K_STI = 4'h2, K_SUB = 4'h3,
    K_SAVE = 4'h4, K_TEST = 4'h5, K_VER = 4'h6, K_WAIT = 4'h7,
    K_FLUSH = 4'h8, K_MSRW = 4'h9, K_EXCHANGE_ADD_OP = 4'hA, K_SWAP_OP = 4'hB,
    K_XOR = 4'hC
  } xtd_kind_t;
endpackage

/* File: core/xtd_alu.sv */
// Purpose: Result and flag computation for subtract, test, exclusive OR, add.
// Assumes: Operands sized by width parameter.
// Notes: Result and flags are registered.
`timescale 1ns/10ps
`default_nettype none
module xtd_alu
  import xtd_pkg::*;
#(
  parameter int W = 32
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [1:0] aluOp,
  input wire logic [W-1:0] opA,
  input wire logic [W-1:0] opB,
  output logic [W-1:0] result,
  output logic [11:0] flagsOut
);
  typedef struct packed {
    logic [W-1:0] res;
    logic [11:0] fl;
  } xtd_alu_state_t;
  xtd_alu_state_t s_reg;
  xtd_alu_state_t s_next;
  logic [W:0] wide;
  always_comb begin
    s_next = s_reg;
    wide = {1'b0, opA} - {1'b0, opB};
    s_next.fl = 12'h000;
    unique case (aluOp)
      2'h0: begin
        s_next.res = wide[W-1:0];
        s_next.fl[FL_CF] = wide[W];
        s_next.fl[FL_AF] = opA[4] ^ opB[4] ^ wide[4];
        s_next.fl[FL_OF] = (opA[W-1] ^ opB[W-1]) & (opA[W-1] ^ wide[W-1]);
      end
      2'h1: s_next.res = opA & opB;
      2'h2: s_next.res = opA ^ opB;
      2'h3: begin
        wide = {1'b0, opA} + {1'b0, opB};
        s_next.res = wide[W-1:0];
        s_next.fl[FL_CF] = wide[W];
        s_next.fl[FL_AF] = opA[4] ^ opB[4] ^ wide[4];
        s_next.fl[FL_OF] = ~(opA[W-1] ^ opB[W-1]) & (opA[W-1] ^ wide[W-1]);
      end
    endcase
    s_next.fl[FL_SF] = s_next.res[W-1];
    s_next.fl[FL_ZF] = (s_next.res == '0);
    s_next.fl[FL_PF] = ~(^s_next.res[7:0]);
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign result = s_reg.res;
  assign flagsOut = s_reg.fl;
endmodule
`default_nettype wire

/* File: core/xtd_cycle_timer.sv */
// Purpose: Down counter that times instruction clock counts.
// Assumes: Load has priority over counting.
// Notes: Done pulses one cycle when the count expires.
`timescale 1ns/10ps
`default_nettype none
module xtd_cycle_timer
  import xtd_pkg::*;
#(
  parameter int CW = 8
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic load,
  input wire logic [CW-1:0] count,
  input wire logic hold,
  output logic done
);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic run;
    logic dn;
  } xtd_tmr_state_t;
  xtd_tmr_state_t s_reg;
  xtd_tmr_state_t s_next;
  always_comb begin
    s_next = s_reg;
    s_next.dn = 1'b0;
    if (load) begin
      s_next.cnt = count;
      s_next.run = 1'b1;
    end else if (s_reg.run && !hold) begin
      if (s_reg.cnt <= CW'(1)) begin
        s_next.run = 1'b0;
        s_next.dn = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt - CW'(1);
      end
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign done = s_reg.dn;
endmodule
`default_nettype wire

/* File: core/xtd_decoder.sv */
// Purpose: Decode and sequence the tail group of integer instructions.
// Assumes: Operands, privilege and cache status supplied by neighbours.
// Notes: One instruction at a time; issue only while ready is high.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Opcode FD sets direction flag only, 4 clocks.
// - Opcode FB sets interrupt enable only, 6 clocks.
// - Subtract forms update all six arithmetic flags, 1 clock.
// - Save segment and descriptor: 20 clocks, no flags, management checks.
// - Save local table and descriptor: 20 clocks, no flags, checks.
// - Save task register and descriptor: 21 clocks, no flags, checks.
// - Test clears overflow and carry, sets sign zero parity, 1 clock.
// - Verify read or write: protected only, result in zero, 8 clocks.
// - Wait stalls until floating unit not busy, 1 clock base.
// - Flush writes modified lines then invalidates, 23 clock base.
// - Opcode 0F 30 is a model register write, flags unchanged.
// - Exchange and add swaps, stores sum, six flags, 2 clocks.
// - Exchange swaps operands, no flags, 2 clocks.
// - Exclusive OR clears overflow, carry and adjust, sets sign zero parity, 1 clock.
// - Protected-only instruction in real mode raises vector 6.
// - Real mode beyond FFFFH raises 13, stack limit raises 12.
// - Implicitly locked memory exchange asserts bus lock regardless.
// - Bus lock held during descriptor table reads of verify.
// - Set interrupt with privilege above I/O level raises 13.
// - Verify privilege violation clears zero instead of faulting.
// - Save descriptor ops raise 6 unless management conditions hold.
// - Write-back flush time adds clocks for modified line writes.
module xtd_decoder
  import xtd_pkg::*;
#(
  parameter int W = 32
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic instValid,
  input wire logic [7:0] opByte0,
  input wire logic [7:0] opByte1,
  input wire logic [7:0] modrmByte,
  input wire logic protMode,
  input wire logic [1:0] currentPrivilege,
  input wire logic [1:0] ioPrivilege,
  input wire logic memOperand,
  input wire logic stackOperand,
  input wire logic [31:0] opEndOffset,
  input wire logic [W-1:0] srcA,
  input wire logic [W-1:0] srcB,
  input wire logic [11:0] flagsIn,
  input wire logic fpuBusy,
  input wire logic sysMgmtEnable,
  input wire logic sysMgmtRegionNonzero,
  input wire logic sysMgmtAccessBit,
  input wire logic inSysMgmtHandler,
  input wire logic selectorOk,
  input wire logic writeBackMode,
  input wire logic flushLineBusy,
  input wire logic descAccess,
  output logic ready,
  output logic instDone,
  output logic [11:0] flagsOut,
  output logic [W-1:0] destOut,
  output logic [W-1:0] swapOut,
  output logic destWrite,
  output logic msrWrite,
  output logic busLock,
  output logic cacheFlush,
  output logic cacheInvalidate,
  output logic faultValid,
  output logic [4:0] faultVector
);
  typedef struct packed {
    xtd_state_t st;
    xtd_kind_t kind;
    logic memOp;
    logic [11:0] flags;
    logic [W-1:0] dest;
    logic [W-1:0] swap;
    logic [1:0] aluOp;
    logic rdy;
    logic dn;
    logic dwr;
    logic msr;
    logic lck;
    logic fls;
    logic inv;
    logic flt;
    logic [4:0] vec;
  } xtd_dec_state_t;
  xtd_dec_state_t s_reg;
  xtd_dec_state_t s_next;
  xtd_kind_t dk;
  logic [7:0] cycles;
  logic tmrLoad;
  logic tmrHold;
  logic tmrDone;
  logic [W-1:0] aluRes;
  logic [11:0] aluFl;
  logic [1:0] aluSel;
  logic saveOk;
  logic [2:0] rf;
  function automatic xtd_kind_t decode_kind(input logic [7:0] b0,
      input logic [7:0] b1, input logic [7:0] m);
    xtd_kind_t k;
    k = K_NONE;
    if (b0 == OP_STD) k = K_STD;
    else if (b0 == OP_STI) k = K_STI;
    else if (b0 == OP_WAIT) k = K_WAIT;
    else if (b0[7:2] == 6'h0A) k = K_SUB;
    else if (b0[7:1] == 7'h16) k = K_SUB;
    else if (b0[7:2] == 6'h0C) k = K_XOR;
    else if (b0[7:1] == 7'h1A) k = K_XOR;
    else if (b0[7:1] == 7'h42 || b0[7:1] == 7'h54) k = K_TEST;
    else if (b0[7:1] == 7'h7B && m[5:3] == REG_ZERO) k = K_TEST;
    else if (b0[7:1] == 7'h43 || b0[7:3] == 5'h12) k = K_SWAP_OP;
    else if (b0[7:2] == 6'h20 && m[5:3] == REG_SUB) k = K_SUB;
    else if (b0[7:2] == 6'h20 && m[5:3] == REG_XOR) k = K_XOR;
    else if (b0 == OP_ESC) begin
      if (b1 == OP2_SVSEG) k = K_SAVE;
      else if ((b1 == OP2_SAVE_LOCAL_TABLE_OP || b1 == OP2_SVTSK) &&
               m[5:3] == REG_ZERO) k = K_SAVE;
      else if (b1 == OP2_GRP6 &&
               (m[5:3] == REG_VRD || m[5:3] == REG_VWR)) k = K_VER;
      else if (b1 == OP2_FLUSH) k = K_FLUSH;
      else if (b1 == OP2_MSRW) k = K_MSRW;
      else if (b1[7:1] == OP2_EXCHANGE_ADD_OP) k = K_EXCHANGE_ADD_OP;
    end
    return k;
  endfunction
  assign dk = decode_kind(opByte0, opByte1, modrmByte);
  assign rf = modrmByte[5:3];
  assign saveOk = sysMgmtEnable && sysMgmtRegionNonzero &&
    currentPrivilege == 2'h0 && (sysMgmtAccessBit || inSysMgmtHandler);
  always_comb begin
    unique case (dk)
      K_STD: cycles = CYC_STD;
      K_STI: cycles = CYC_STI;
      K_SAVE: cycles = (opByte1 == OP2_SVTSK) ? CYC_SVTSK : CYC_SVSEG;
      K_VER: cycles = CYC_VER;
      K_WAIT: cycles = CYC_WAIT;
      K_FLUSH: cycles = CYC_FLUSH;
      K_MSRW: cycles = CYC_MSRW;
      K_EXCHANGE_ADD_OP, K_SWAP_OP: cycles = CYC_XCH;
      default: cycles = CYC_ALU;
    endcase
    unique case (dk)
      K_TEST: aluSel = 2'h1;
      K_XOR: aluSel = 2'h2;
      K_EXCHANGE_ADD_OP: aluSel = 2'h3;
      default: aluSel = 2'h0;
    endcase
  end
  assign tmrLoad = s_reg.st == ST_IDLE && s_next.st == ST_EXEC;
  assign tmrHold = 1'b0;
  xtd_cycle_timer #(.CW(8)) u_timer (
    .mclk(mclk),
    .rstn(rstn),
    .load(tmrLoad),
    .count(cycles),
    .hold(tmrHold),
    .done(tmrDone)
  );
  xtd_alu #(.W(W)) u_alu (
    .mclk(mclk),
    .rstn(rstn),
    .aluOp(s_reg.aluOp),
    .opA(srcA),
    .opB(srcB),
    .result(aluRes),
    .flagsOut(aluFl)
  );
  always_comb begin
    s_next = s_reg;
    s_next.dn = 1'b0;
    s_next.dwr = 1'b0;
    s_next.msr = 1'b0;
    s_next.flt = 1'b0;
    s_next.inv = 1'b0;
    unique case (s_reg.st)
      ST_IDLE: begin
        s_next.rdy = 1'b1;
        if (instValid && s_reg.rdy) begin
          s_next.rdy = 1'b0;
          s_next.kind = dk;
          s_next.memOp = memOperand;
          s_next.flags = flagsIn;
          s_next.aluOp = aluSel;
          s_next.st = ST_LOCKD;
          if (dk == K_NONE || (dk == K_VER && !protMode)) begin
            s_next.vec = VEC_UD;
          end else if (dk == K_SAVE && !saveOk) begin
            s_next.vec = VEC_UD;
          end else if (!protMode && memOperand &&
                       opEndOffset > REAL_LIMIT) begin
            s_next.vec = stackOperand ? VEC_SS : VEC_GP;
          end else if (dk == K_STI && protMode &&
                       currentPrivilege > ioPrivilege) begin
            s_next.vec = VEC_GP;
          end else begin
            s_next.st = ST_EXEC;
            if (dk == K_SWAP_OP && memOperand) s_next.lck = 1'b1;
          end
        end
      end
      ST_EXEC: begin
        if (s_reg.kind == K_VER) s_next.lck = descAccess;
        if (tmrDone) begin
          if (s_reg.kind == K_WAIT && fpuBusy) s_next.st = ST_WAITF;
          else if (s_reg.kind == K_FLUSH) begin
            s_next.fls = writeBackMode;
            s_next.st = ST_FLUSH;
          end else s_next.st = ST_DONE;
        end
      end
      ST_WAITF: if (!fpuBusy) s_next.st = ST_DONE;
      ST_FLUSH: begin
        if (!flushLineBusy || !writeBackMode) begin
          s_next.fls = 1'b0;
          s_next.inv = 1'b1;
          s_next.st = ST_DONE;
        end
      end
      ST_LOCKD: begin
        s_next.flt = 1'b1;
        s_next.st = ST_DONE;
      end
      ST_DONE: begin
        s_next.lck = 1'b0;
        s_next.st = ST_IDLE;
        s_next.rdy = 1'b1;
        if (!s_reg.flt) begin
          s_next.dn = 1'b1;
          unique case (s_reg.kind)
            K_STD: s_next.flags[FL_DF] = 1'b1;
            K_STI: s_next.flags[FL_IF] = 1'b1;
            K_SUB, K_EXCHANGE_ADD_OP: begin
              s_next.flags[FL_OF] = aluFl[FL_OF];
              s_next.flags[FL_SF] = aluFl[FL_SF];
              s_next.flags[FL_ZF] = aluFl[FL_ZF];
              s_next.flags[FL_AF] = aluFl[FL_AF];
              s_next.flags[FL_PF] = aluFl[FL_PF];
              s_next.flags[FL_CF] = aluFl[FL_CF];
              s_next.dest = aluRes;
              s_next.swap = srcA;
              s_next.dwr = 1'b1;
            end
            K_TEST, K_XOR: begin
              s_next.flags[FL_OF] = 1'b0;
              s_next.flags[FL_CF] = 1'b0;
              s_next.flags[FL_SF] = aluFl[FL_SF];
              s_next.flags[FL_ZF] = aluFl[FL_ZF];
              s_next.flags[FL_PF] = aluFl[FL_PF];
              s_next.flags[FL_AF] = 1'b0;
              s_next.dest = aluRes;
              s_next.dwr = (s_reg.kind == K_XOR);
            end
            K_VER: s_next.flags[FL_ZF] = selectorOk;
            K_SWAP_OP: begin
              s_next.dest = srcB;
              s_next.swap = srcA;
              s_next.dwr = 1'b1;
            end
            K_MSRW: s_next.msr = 1'b1;
            default: s_next.dwr = 1'b0;
          endcase
        end
      end
      default: s_next.st = ST_IDLE;
    endcase
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.kind <= K_NONE;
      s_reg.flags <= FLAGS_RESET;
    end else begin
      s_reg <= s_next;
    end
  end
  assign ready = s_reg.rdy;
  assign instDone = s_reg.dn;
  assign flagsOut = s_reg.flags;
  assign destOut = s_reg.dest;
  assign swapOut = s_reg.swap;
  assign destWrite = s_reg.dwr;
  assign msrWrite = s_reg.msr;
  assign busLock = s_reg.lck;
  assign cacheFlush = s_reg.fls;
  assign cacheInvalidate = s_reg.inv;
  assign faultValid = s_reg.flt;
  assign faultVector = s_reg.vec;
endmodule
`default_nettype wire

/* File: verif/xtd_far_model.sv */
// Purpose: Far side model of floating unit busy and line write-back.
// Assumes: Line writes start when the decoder raises cacheFlush.
// Notes: Busy lengths are parameters.
`timescale 1ns/10ps
`default_nettype none
module xtd_far_model
  import xtd_pkg::*;
#(
  parameter int FPU_CYC = 6,
  parameter int LINES = 5
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic fpuStart,
  input wire logic cacheFlush,
  output logic fpuBusy,
  output logic flushLineBusy
);
  int fpuCnt_reg;
  int lineCnt_reg;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fpuCnt_reg <= 0;
      lineCnt_reg <= 0;
    end else begin
      fpuCnt_reg <= fpuStart ? FPU_CYC : (fpuCnt_reg > 0 ? fpuCnt_reg - 1 : 0);
      lineCnt_reg <= cacheFlush ? lineCnt_reg + 1 : 0;
    end
  end
  assign fpuBusy = fpuCnt_reg > 0;
  // Modified lines are written one a clock while the flush stands.
  assign flushLineBusy = cacheFlush && lineCnt_reg < LINES;
endmodule
`default_nettype wire

/* File: verif/xtd_decoder_properties.sv */
// Purpose: Port checks for the tail instruction decoder.
// Assumes: A take is ready and instValid high at one edge.
// Notes: Bound from the bench top file.
`timescale 1ns/10ps
`default_nettype none
module xtd_decoder_checker
  import xtd_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic instValid,
  input wire logic [7:0] opByte0,
  input wire logic [7:0] opByte1,
  input wire logic [7:0] modrmByte,
  input wire logic protMode,
  input wire logic [1:0] currentPrivilege,
  input wire logic [1:0] ioPrivilege,
  input wire logic memOperand,
  input wire logic stackOperand,
  input wire logic [31:0] opEndOffset,
  input wire logic [11:0] flagsIn,
  input wire logic sysMgmtEnable,
  input wire logic sysMgmtRegionNonzero,
  input wire logic sysMgmtAccessBit,
  input wire logic inSysMgmtHandler,
  input wire logic selectorOk,
  input wire logic ready,
  input wire logic instDone,
  input wire logic [11:0] flagsOut,
  input wire logic busLock,
  input wire logic faultValid,
  input wire logic [4:0] faultVector
);
  wire take = ready && instValid;
  wire esc = take && opByte0 == OP_ESC;
  wire smOk = sysMgmtEnable && sysMgmtRegionNonzero &&
    currentPrivilege == 2'h0 && (sysMgmtAccessBit || inSysMgmtHandler);
  wire isVer = esc && opByte1 == OP2_GRP6 &&
    modrmByte[5:3] inside {REG_VRD, REG_VWR};
  wire stiBad = protMode && currentPrivilege > ioPrivilege;
  wire isSave = esc && opByte1 inside {OP2_SVSEG, OP2_SAVE_LOCAL_TABLE_OP, OP2_SVTSK};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  std_timing_a: assert property (take && opByte0 == OP_STD |->
    ##1 !instDone [*6] ##1 (instDone && flagsOut == ($past(flagsIn, 7) |
    12'h400))) else $error("set direction timing or flags wrong");
  sti_timing_a: assert property (take && opByte0 == OP_STI &&
    !stiBad |-> ##9 (instDone && flagsOut[FL_IF]))
    else $error("set interrupt timing or flag wrong");
  sti_priv_a: assert property (take && opByte0 == OP_STI &&
    stiBad |-> ##2 (faultValid && faultVector == VEC_GP))
    else $error("set interrupt privilege fault missing");
  alu_time_a: assert property (take && !memOperand &&
    opByte0 inside {8'h29, 8'h31, 8'h85} |-> ##1 !instDone [*3] ##1 instDone)
    else $error("single clock operation timing wrong");
  save_time_a: assert property (esc && opByte1 == OP2_SVTSK && smOk &&
    !memOperand |-> ##24 instDone) else $error("task save timing wrong");
  save_fault_a: assert property (isSave && !smOk |->
    ##2 (faultValid && faultVector == VEC_UD))
    else $error("save instruction fault missing");
  ver_real_a: assert property (isVer && !protMode |->
    ##2 (faultValid && faultVector == VEC_UD))
    else $error("verify in real mode not refused");
  ver_zero_a: assert property (isVer && protMode |->
    ##11 (instDone && flagsOut[FL_ZF] == $past(selectorOk, 11)))
    else $error("verify result wrong");
  swap_lock_a: assert property (take && opByte0[7:1] == 7'h43 &&
    memOperand && protMode |-> ##1 busLock [*4])
    else $error("memory exchange not locked");
  real_limit_a: assert property (take && !protMode && memOperand &&
    opByte0 == 8'h87 && opEndOffset > REAL_LIMIT |-> ##2 (faultValid &&
    faultVector == ($past(stackOperand, 2) ? VEC_SS : VEC_GP)))
    else $error("real mode limit fault wrong");
endmodule
`default_nettype wire

/* File: verif/xtd_decoder_tb.sv */
// Purpose: Bench for the tail instruction decoder.
// Assumes: Inputs change on the falling clock edge.
// Notes: Each run issues one instruction and times its answer.
`timescale 1ns/10ps
`default_nettype none
module xtd_decoder_tb
  import xtd_pkg::*;
;
  logic mclk = 1'b0;
  logic rstn, instValid, protMode, memOperand, stackOperand;
  logic fpuBusy, sysMgmtEnable, sysMgmtRegionNonzero, sysMgmtAccessBit;
  logic inSysMgmtHandler, selectorOk, writeBackMode, flushLineBusy;
  logic descAccess, ready, instDone, destWrite, msrWrite, busLock;
  logic cacheFlush, cacheInvalidate, faultValid, fpuStart, sawFlush, sawInval;
  logic [7:0] opByte0, opByte1, modrmByte;
  logic [1:0] currentPrivilege, ioPrivilege;
  logic [31:0] opEndOffset, srcA, srcB, destOut, swapOut;
  logic [11:0] flagsIn, flagsOut;
  logic [4:0] faultVector;
  int n_mismatch, n_tests, c;
  xtd_decoder #(.W(32)) dut (
    .mclk(mclk), .rstn(rstn), .instValid(instValid), .opByte0(opByte0),
    .opByte1(opByte1), .modrmByte(modrmByte), .protMode(protMode),
    .currentPrivilege(currentPrivilege), .ioPrivilege(ioPrivilege),
    .memOperand(memOperand), .stackOperand(stackOperand),
    .opEndOffset(opEndOffset), .srcA(srcA), .srcB(srcB), .flagsIn(flagsIn),
    .fpuBusy(fpuBusy), .sysMgmtEnable(sysMgmtEnable),
    .sysMgmtRegionNonzero(sysMgmtRegionNonzero),
    .sysMgmtAccessBit(sysMgmtAccessBit), .inSysMgmtHandler(inSysMgmtHandler),
    .selectorOk(selectorOk), .writeBackMode(writeBackMode),
    .flushLineBusy(flushLineBusy), .descAccess(descAccess), .ready(ready),
    .instDone(instDone), .flagsOut(flagsOut), .destOut(destOut),
    .swapOut(swapOut), .destWrite(destWrite), .msrWrite(msrWrite),
    .busLock(busLock), .cacheFlush(cacheFlush),
    .cacheInvalidate(cacheInvalidate), .faultValid(faultValid),
    .faultVector(faultVector)
  );
  xtd_far_model #(.FPU_CYC(6), .LINES(5)) far (
    .mclk(mclk), .rstn(rstn), .fpuStart(fpuStart), .cacheFlush(cacheFlush),
    .fpuBusy(fpuBusy), .flushLineBusy(flushLineBusy)
  );
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (!rstn) begin
      {sawFlush, sawInval} <= 2'b00;
    end else begin
      if (cacheFlush === 1'b1) sawFlush <= 1'b1;
      if (cacheInvalidate === 1'b1) sawInval <= 1'b1;
    end
  end
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic results();
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tick();
    @(negedge mclk);
    c++;
    if (c > 400) begin
      n_mismatch++;
      results();
    end
  endtask
  // Issues one instruction, then counts clocks to its answer.
  task automatic run(input logic [7:0] b0, input logic [7:0] b1,
    input logic [7:0] m, input int n, input logic [4:0] v);
    c = 0;
    while (ready !== 1'b1) tick();
    opByte0 = b0;
    opByte1 = b1;
    modrmByte = m;
    instValid = 1'b1;
    @(negedge mclk);
    instValid = 1'b0;
    // The count names the rising edge at which the answer is sampled.
    c = 1;
    while (instDone !== 1'b1 && faultValid !== 1'b1) tick();
    if (n >= 0) check(c, n);
    check((faultValid === 1'b1) ? faultVector : 5'h00, v);
  endtask
  initial begin
    {rstn, instValid, protMode, memOperand, stackOperand} = '0;
    {sysMgmtEnable, sysMgmtRegionNonzero, sysMgmtAccessBit} = '0;
    {inSysMgmtHandler, selectorOk, writeBackMode, descAccess} = '0;
    {fpuStart, opByte0, opByte1, modrmByte} = '0;
    {currentPrivilege, ioPrivilege, opEndOffset, srcA, srcB} = '0;
    flagsIn = 12'h000;
    n_mismatch = 0;
    n_tests = 0;
    repeat (3) @(negedge mclk);
    rstn = 1'b1;
    run(OP_STD, 8'h00, 8'h00, 7, 5'h00);
    check(flagsOut, 12'h400);
    flagsIn = 12'h801;
    run(OP_STI, 8'h00, 8'h00, 9, 5'h00);
    check(flagsOut, 12'hA01);
    protMode = 1'b1;
    currentPrivilege = 2'h3;
    run(OP_STI, 8'h00, 8'h00, 2, VEC_GP);
    {protMode, currentPrivilege, srcB} = {3'h0, 32'h1};
    run(8'h29, 8'h00, 8'hC1, 4, 5'h00);
    check(flagsOut, 12'h095);
    check(destOut, 32'hFFFFFFFF);
    {srcA, srcB} = {32'hF0, 32'h0F};
    run(8'h31, 8'h00, 8'hC1, 4, 5'h00);
    check(flagsOut, 12'h004);
    check(destWrite, 1'b1);
    {srcA, srcB} = {2{32'h80000000}};
    run(8'h85, 8'h00, 8'hC1, 4, 5'h00);
    check(flagsOut, 12'h084);
    check(destWrite, 1'b0);
    {srcA, srcB} = {32'h3, 32'h4};
    run(OP_ESC, 8'hC1, 8'hC0, 5, 5'h00);
    check({flagsOut, destOut, swapOut}, {12'h000, 32'h7, 32'h3});
    {protMode, memOperand} = 2'b11;
    run(8'h87, 8'h00, 8'h00, 5, 5'h00);
    check({flagsOut, destOut, swapOut}, {12'h801, 32'h4, 32'h3});
    {protMode, opEndOffset} = {1'b0, 32'h00010000};
    run(8'h87, 8'h00, 8'h00, 2, VEC_GP);
    stackOperand = 1'b1;
    run(8'h87, 8'h00, 8'h00, 2, VEC_SS);
    {stackOperand, opEndOffset} = {1'b0, REAL_LIMIT};
    run(8'h87, 8'h00, 8'h00, 5, 5'h00);
    memOperand = 1'b0;
    run(OP_ESC, OP2_MSRW, 8'h00, 4, 5'h00);
    check(flagsOut, 12'h801);
    check(msrWrite, 1'b1);
    for (int i = 0; i < 2; i++) begin
      {sysMgmtEnable, sysMgmtRegionNonzero, sysMgmtAccessBit} = {3{i[0]}};
      run(OP_ESC, OP2_SVSEG, 8'h08, i ? 23 : 2, i ? 5'h00 : VEC_UD);
      run(OP_ESC, OP2_SAVE_LOCAL_TABLE_OP, 8'h00, i ? 23 : 2, i ? 5'h00 : VEC_UD);
      run(OP_ESC, OP2_SVTSK, 8'h00, i ? 24 : 2, i ? 5'h00 : VEC_UD);
    end
    check(flagsOut, 12'h801);
    {sysMgmtAccessBit, inSysMgmtHandler} = 2'b01;
    run(OP_ESC, OP2_SVTSK, 8'h00, 24, 5'h00);
    currentPrivilege = 2'h1;
    run(OP_ESC, OP2_SVTSK, 8'h00, 2, VEC_UD);
    run(OP_ESC, OP2_GRP6, 8'h20, 2, VEC_UD);
    {protMode, descAccess} = 2'b11;
    for (int i = 0; i < 2; i++) begin
      selectorOk = i[0];
      run(OP_ESC, OP2_GRP6, i ? 8'h20 : 8'h28, 11, 5'h00);
      check(flagsOut[FL_ZF], i[0]);
    end
    run(OP_WAIT, 8'h00, 8'h00, 4, 5'h00);
    fpuStart = 1'b1;
    @(negedge mclk);
    fpuStart = 1'b0;
    run(OP_WAIT, 8'h00, 8'h00, -1, 5'h00);
    check(c > 4, 1'b1);
    writeBackMode = 1'b1;
    run(OP_ESC, OP2_FLUSH, 8'h00, -1, 5'h00);
    check({c == 27 + 5, sawFlush, sawInval}, 3'b111);
    results();
  end
endmodule
bind xtd_decoder xtd_decoder_checker chk (
  .mclk(mclk), .rstn(rstn), .instValid(instValid), .opByte0(opByte0),
  .opByte1(opByte1), .modrmByte(modrmByte), .protMode(protMode),
  .currentPrivilege(currentPrivilege), .ioPrivilege(ioPrivilege),
  .memOperand(memOperand), .stackOperand(stackOperand),
  .opEndOffset(opEndOffset), .flagsIn(flagsIn),
  .sysMgmtEnable(sysMgmtEnable), .sysMgmtRegionNonzero(sysMgmtRegionNonzero),
  .sysMgmtAccessBit(sysMgmtAccessBit), .inSysMgmtHandler(inSysMgmtHandler),
  .selectorOk(selectorOk), .ready(ready), .instDone(instDone),
  .flagsOut(flagsOut), .busLock(busLock), .faultValid(faultValid),
  .faultVector(faultVector)
);
`default_nettype wire
